// [design/bal_map.svh]
`ifndef BAL_MAP_SVH
`define BAL_MAP_SVH
`define BAL_WORK_RESET      8'h00
`define BAL_AUX_RESET       8'h00
`define BAL_LOW_FIX         8'h06
`define BAL_HIGH_FIX        8'h60
`define BAL_DIGIT_MAX       4'h9
`define BAL_BCD_MAX         9'h099
`define BAL_BYTE_MAX        16'h00ff
`define BAL_DIV_STEPS       4'h8
`endif

// [design/bal_pkg.sv]
package bal_pkg;
	typedef enum logic [3:0]
	{
		BAL_OP_NONE  = 4'h0,
		BAL_OP_ADD   = 4'h1,
		BAL_OP_ADD_CARRY = 4'h2,
		BAL_OP_SUB   = 4'h3,
		BAL_OP_PROD  = 4'h4,
		BAL_OP_DIV   = 4'h5,
		BAL_OP_BCD   = 4'h6,
		BAL_OP_ROR   = 4'h7,
		BAL_OP_ROL   = 4'h8,
		BAL_OP_CMP   = 4'h9,
		BAL_OP_LOAD  = 4'ha
	} bal_op_e;
	typedef enum logic [1:0]
	{
		BAL_ST_IDLE = 2'b00,
		BAL_ST_DIV  = 2'b01,
		BAL_ST_DONE = 2'b11
	} bal_state_e;
endpackage

// [design/bal_divider.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bal_map.svh"
// Restoring divider: one quotient bit per cycle, eight cycles per division.
module bal_divider
(
	// Clock and reset.
	input  wire logic       clock,
	input  wire logic       rst,
	// Request.
	input  wire logic       start,
	input  wire logic [7:0] dividend,
	input  wire logic [7:0] divisor,
	// Answer.
	output logic            done,
	output logic      [7:0] quotient,
	output logic      [7:0] remainder
);
	logic [3:0] steps;
	logic [7:0] dvs;
	logic       busy;
	logic [8:0] trial;

	always_comb
	begin
		trial = {remainder, quotient[7]} - {1'b0, dvs};
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			busy      <= 1'b0;
			done      <= 1'b0;
			steps     <= 4'h0;
			dvs       <= 8'h00;
			quotient  <= 8'h00;
			remainder <= 8'h00;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				busy      <= 1'b1;
				steps     <= `BAL_DIV_STEPS;
				dvs       <= divisor;
				quotient  <= dividend;
				remainder <= 8'h00;
			end
			else if (busy)
			begin
				if (trial[8])
				begin
					remainder <= {remainder[6:0], quotient[7]};
					quotient  <= {quotient[6:0], 1'b0};
				end
				else
				begin
					remainder <= trial[7:0];
					quotient  <= {quotient[6:0], 1'b1};
				end
				steps <= steps - 4'h1;
				if (steps == 4'h1)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [design/bal_alu.sv]
// What this block does
// - Plain add puts work register plus source back into the work register.
// - Add with carry adds source and carry flag to the work register.
// - Both adds set carry on carry out of bit 7, else clear.
// - Both adds set signed wrap to carry out of bit 6 xor bit 7.
// - Both adds set nibble carry on carry out of bit 3.
// - Subtract with borrow takes source and carry from the work register.
// - Subtract sets carry when bit 7 needs a borrow.
// - Subtract sets signed wrap when exactly one of bits 6, 7 borrows.
// - Subtract sets nibble carry when bit 3 needs a borrow.
// - Multiply work by auxiliary unsigned; low byte to work, high to auxiliary.
// - Multiply clears carry; signed wrap set when product exceeds 255.
// - Divide unsigned: quotient to work, remainder to auxiliary (both kept if divisor is zero), carry cleared.
// - Divide clears signed wrap unless divisor is zero, which sets it.
// - Decimal fix adds 06h if nibble carry set or low digit above 9.
// - Decimal fix then adds 60h if carry was set or low fix applied.
// - Decimal fix sets carry when the result exceeds 99h, else clears.
// - Rotate right through carry: old carry to bit 7, bit 0 to carry.
// - Rotate left through carry: old carry to bit 0, bit 7 to carry.
// - Compare branches when operands differ, falls through when equal.
// - Compare sets carry when source exceeds destination, else clears.
`timescale 1ns/1ps
`default_nettype none
`include "bal_map.svh"
module bal_alu
(
	// Clock and reset.
	input  wire logic           clock,
	input  wire logic           rst,
	// Operation request from the sequencer.
	input  wire logic           op_valid,
	input  wire bal_pkg::bal_op_e op_code,
	input  wire logic     [7:0] src_operand,
	input  wire logic     [7:0] dst_operand,
	// Direct register loads from the sequencer.
	input  wire logic           load_aux,
	input  wire logic     [7:0] aux_load_value,
	input  wire logic           flag_load,
	input  wire logic     [2:0] flag_load_value,
	// Results.
	output logic                op_ready,
	output logic                op_done,
	output logic          [7:0] work_reg,
	output logic          [7:0] aux_reg,
	output logic                carry_flag,
	output logic                signed_wrap_flag,
	output logic                nibble_carry_flag,
	output logic                branch_taken
);
	////////////////////////////////////////////////////////////////////////////
	bal_pkg::bal_state_e state;
	logic       accept;
	logic       div_start;
	logic       div_done;
	logic [7:0] div_quot;
	logic [7:0] div_rem;
	logic [8:0] sum_lo;
	logic [8:0] sum_mid;
	logic [8:0] add_full;
	logic [4:0] dif_lo;
	logic [7:0] dif_mid;
	logic [8:0] sub_full;
	logic [15:0] product;
	logic       low_fix;
	logic       high_fix;
	logic [8:0] bcd_step1;
	logic [8:0] bcd_step2;
	logic       add_cin;
	logic       sub_bin;
	logic       div_zero;

	// Carry out of bit 6 is bit 7 of a sum over the low seven bits.
	function automatic logic [8:0] bal_add(input logic [7:0] a, input logic [7:0] b,
		input logic c);
		bal_add = {1'b0, a} + {1'b0, b} + {8'h00, c};
	endfunction

	assign op_ready = (state == bal_pkg::BAL_ST_IDLE);
	assign accept   = op_valid && op_ready;
	assign div_start = accept && (op_code == bal_pkg::BAL_OP_DIV);

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		add_cin  = (op_code == bal_pkg::BAL_OP_ADD_CARRY) ? carry_flag : 1'b0;
		sub_bin  = carry_flag;
		add_full = bal_add(work_reg, src_operand, add_cin);
		sum_lo   = bal_add({4'h0, work_reg[3:0]}, {4'h0, src_operand[3:0]}, add_cin);
		sum_mid  = bal_add({1'b0, work_reg[6:0]}, {1'b0, src_operand[6:0]}, add_cin);
		sub_full = {1'b0, work_reg} - {1'b0, src_operand} - {8'h00, sub_bin};
		dif_lo   = {1'b0, work_reg[3:0]} - {1'b0, src_operand[3:0]} - {4'h0, sub_bin};
		dif_mid  = {1'b0, work_reg[6:0]} - {1'b0, src_operand[6:0]} - {7'h00, sub_bin};
		product  = {8'h00, work_reg} * {8'h00, aux_reg};
		low_fix  = nibble_carry_flag || (work_reg[3:0] > `BAL_DIGIT_MAX);
		bcd_step1 = low_fix ? bal_add(work_reg, `BAL_LOW_FIX, 1'b0) : {1'b0, work_reg};
		high_fix = carry_flag || low_fix;
		// The low fix may already carry out of bit 7, so the high fix adds on all nine bits.
		bcd_step2 = high_fix ? (bcd_step1 + {1'b0, `BAL_HIGH_FIX}) : bcd_step1;
	end

	////////////////////////////////////////////////////////////////////////////
	bal_divider i_bal_divider
	(
		.clock     (clock),
		.rst       (rst),
		.start     (div_start),
		.dividend  (work_reg),
		.divisor   (aux_reg),
		.done      (div_done),
		.quotient  (div_quot),
		.remainder (div_rem)
	);

	// A zero divisor is judged when the division starts, so a load of the
	// auxiliary register in that same cycle cannot change the outcome.
	always_ff @(posedge clock)
	begin
		if (rst)
			div_zero <= 1'b0;
		else if (div_start)
			div_zero <= (aux_reg == 8'h00);
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			state <= bal_pkg::BAL_ST_IDLE;
		else
		begin
			unique case (state)
				bal_pkg::BAL_ST_IDLE:
					if (div_start)
						state <= bal_pkg::BAL_ST_DIV;
				bal_pkg::BAL_ST_DIV:
					if (div_done)
						state <= bal_pkg::BAL_ST_DONE;
				bal_pkg::BAL_ST_DONE:
					state <= bal_pkg::BAL_ST_IDLE;
				default:
					state <= bal_pkg::BAL_ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Work and auxiliary registers.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			work_reg <= `BAL_WORK_RESET;
			aux_reg  <= `BAL_AUX_RESET;
		end
		else if (state == bal_pkg::BAL_ST_DIV && div_done)
		begin
			if (!div_zero)
			begin
				work_reg <= div_quot;
				aux_reg  <= div_rem;
			end
		end
		else
		begin
			if (load_aux && op_ready)
				aux_reg <= aux_load_value;
			if (accept)
			begin
				unique case (op_code)
					bal_pkg::BAL_OP_ADD, bal_pkg::BAL_OP_ADD_CARRY:
						work_reg <= add_full[7:0];
					bal_pkg::BAL_OP_SUB:
						work_reg <= sub_full[7:0];
					bal_pkg::BAL_OP_PROD:
					begin
						work_reg <= product[7:0];
						aux_reg  <= product[15:8];
					end
					bal_pkg::BAL_OP_BCD:
						work_reg <= bcd_step2[7:0];
					bal_pkg::BAL_OP_ROR:
						work_reg <= {carry_flag, work_reg[7:1]};
					bal_pkg::BAL_OP_ROL:
						work_reg <= {work_reg[6:0], carry_flag};
					bal_pkg::BAL_OP_LOAD:
						work_reg <= src_operand;
					default:
						work_reg <= work_reg;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status flags; an operation leaves every flag it does not name alone.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			carry_flag        <= 1'b0;
			signed_wrap_flag  <= 1'b0;
			nibble_carry_flag <= 1'b0;
		end
		else if (state == bal_pkg::BAL_ST_DIV && div_done)
		begin
			carry_flag       <= 1'b0;
			signed_wrap_flag <= div_zero;
		end
		else if (accept)
		begin
			unique case (op_code)
				bal_pkg::BAL_OP_ADD, bal_pkg::BAL_OP_ADD_CARRY:
				begin
					carry_flag        <= add_full[8];
					signed_wrap_flag  <= add_full[8] ^ sum_mid[7];
					nibble_carry_flag <= sum_lo[4];
				end
				bal_pkg::BAL_OP_SUB:
				begin
					carry_flag        <= sub_full[8];
					signed_wrap_flag  <= sub_full[8] ^ dif_mid[7];
					nibble_carry_flag <= dif_lo[4];
				end
				bal_pkg::BAL_OP_PROD:
				begin
					carry_flag       <= 1'b0;
					signed_wrap_flag <= (product > `BAL_BYTE_MAX);
				end
				bal_pkg::BAL_OP_BCD:
					carry_flag <= bcd_step2[8] || ({1'b0, bcd_step2[7:0]} > `BAL_BCD_MAX);
				bal_pkg::BAL_OP_ROR:
					carry_flag <= work_reg[0];
				bal_pkg::BAL_OP_ROL:
					carry_flag <= work_reg[7];
				bal_pkg::BAL_OP_CMP:
					carry_flag <= (src_operand > dst_operand);
				default:
				begin
					if (flag_load)
					begin
						carry_flag        <= flag_load_value[2];
						signed_wrap_flag  <= flag_load_value[1];
						nibble_carry_flag <= flag_load_value[0];
					end
				end
			endcase
		end
		else if (flag_load && op_ready)
		begin
			carry_flag        <= flag_load_value[2];
			signed_wrap_flag  <= flag_load_value[1];
			nibble_carry_flag <= flag_load_value[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Completion and branch decision.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			op_done      <= 1'b0;
			branch_taken <= 1'b0;
		end
		else
		begin
			op_done      <= (accept && !div_start) || (state == bal_pkg::BAL_ST_DIV && div_done);
			branch_taken <= accept && (op_code == bal_pkg::BAL_OP_CMP)
				&& (src_operand != dst_operand);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	AST_ADD_RESULT: assert property (@(posedge clock) disable iff (rst)
		accept && op_code == bal_pkg::BAL_OP_ADD |=> work_reg == 8'($past(work_reg) + $past(src_operand)))
		else $error("Add result wrong.");
	AST_ADD_CARRY_OUT: assert property (@(posedge clock) disable iff (rst)
		accept && op_code == bal_pkg::BAL_OP_ADD_CARRY |=> carry_flag ==
		((9'($past(work_reg)) + 9'($past(src_operand)) + 9'($past(carry_flag))) > 9'h0ff))
		else $error("Add with carry flag wrong.");
	AST_SUB_BORROW: assert property (@(posedge clock) disable iff (rst)
		accept && op_code == bal_pkg::BAL_OP_SUB |=> carry_flag ==
		(9'($past(src_operand)) + 9'($past(carry_flag)) > 9'($past(work_reg))))
		else $error("Subtract borrow wrong.");
	AST_PROD_WRAP: assert property (@(posedge clock) disable iff (rst)
		accept && op_code == bal_pkg::BAL_OP_PROD |=> !carry_flag && (signed_wrap_flag == (aux_reg != 8'h00)))
		else $error("Multiply flags wrong.");
	AST_DIV_FINISH: assert property (@(posedge clock) disable iff (rst)
		div_start |-> ##[9:10] op_done)
		else $error("Divide did not finish in time.");
	AST_DIV_ZERO: assert property (@(posedge clock) disable iff (rst)
		div_start && aux_reg == 8'h00 |-> ##10 signed_wrap_flag && !carry_flag)
		else $error("Divide by zero flag wrong.");
	AST_ROR_CARRY: assert property (@(posedge clock) disable iff (rst)
		accept && op_code == bal_pkg::BAL_OP_ROR |=> carry_flag == $past(work_reg[0])
		&& work_reg[7] == $past(carry_flag))
		else $error("Rotate right wrong.");
	AST_CMP_BRANCH: assert property (@(posedge clock) disable iff (rst)
		accept && op_code == bal_pkg::BAL_OP_CMP |=> branch_taken == ($past(src_operand) != $past(dst_operand)))
		else $error("Compare branch wrong.");
	AST_ROT_KEEP: assert property (@(posedge clock) disable iff (rst)
		accept && op_code == bal_pkg::BAL_OP_ROL && !flag_load |=> $stable(nibble_carry_flag) && $stable(signed_wrap_flag))
		else $error("Untouched flag changed.");
endmodule
`default_nettype wire

// [tb/bal_seq_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Sequencer stand-in: one request at a time; idle data lines show the inverse of the last value.
module bal_seq_model
(
	// Clock.
	input  wire logic                 clock,
	// Answer from the datapath.
	input  wire logic                 op_ready,
	input  wire logic                 op_done,
	input  wire logic                 branch_taken,
	// Request to the datapath.
	output var  logic                 op_valid,
	output var  bal_pkg::bal_op_e     op_code,
	output var  logic           [7:0] src_operand,
	output var  logic           [7:0] dst_operand,
	output var  logic                 load_aux,
	output var  logic           [7:0] aux_load_value,
	output var  logic                 flag_load,
	output var  logic           [2:0] flag_load_value
);
	int   lat;
	logic br;
	task automatic drop(input logic [7:0] s, input logic [7:0] d, input logic [7:0] a,
		input logic [2:0] f);
		op_valid = 1'b0;
		load_aux = 1'b0;
		flag_load = 1'b0;
		src_operand = s;
		dst_operand = d;
		aux_load_value = a;
		flag_load_value = f;
	endtask
	initial
	begin
		op_code = bal_pkg::BAL_OP_NONE;
		drop(8'h00, 8'h00, 8'h00, 3'b000);
	end
	// Hold the request until the taking edge, then wait for the completion pulse.
	task automatic issue(input bal_pkg::bal_op_e op, input logic [7:0] s, input logic [7:0] d,
		input logic la, input logic [7:0] av, input logic fl, input logic [2:0] fv);
		@(negedge clock);
		op_code = op;
		op_valid = 1'b1;
		src_operand = s;
		dst_operand = d;
		load_aux = la;
		aux_load_value = av;
		flag_load = fl;
		flag_load_value = fv;
		lat = 0;
		while (op_ready !== 1'b1 && lat < 20)
		begin
			@(negedge clock);
			lat++;
		end
		@(posedge clock);
		@(negedge clock);
		drop(~s, ~d, ~av, ~fv);
		lat = 1;
		while (op_done !== 1'b1 && lat < 20)
		begin
			@(negedge clock);
			lat++;
		end
		br = branch_taken;
	endtask
endmodule
`default_nettype wire

// [tb/tb_byte_alu_flag_logic.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_byte_alu_flag_logic;
	logic                 clock = 1'b0;
	logic                 rst = 1'b1;
	logic                 op_valid;
	bal_pkg::bal_op_e     op_code;
	logic           [7:0] src_operand;
	logic           [7:0] dst_operand;
	logic                 load_aux;
	logic           [7:0] aux_load_value;
	logic                 flag_load;
	logic           [2:0] flag_load_value;
	logic                 op_ready;
	logic                 op_done;
	logic           [7:0] work_reg;
	logic           [7:0] aux_reg;
	logic                 carry_flag;
	logic                 signed_wrap_flag;
	logic                 nibble_carry_flag;
	logic                 branch_taken;
	logic           [2:0] flg;
	int                   n_mismatch = 0;
	int                   compares = 0;
	localparam logic [7:0] VA [6] = '{8'h7f, 8'hff, 8'h0f, 8'h88, 8'h00, 8'h80};
	localparam logic [7:0] VB [6] = '{8'h01, 8'h01, 8'h01, 8'h88, 8'h01, 8'h01};
	assign flg = {carry_flag, signed_wrap_flag, nibble_carry_flag};
	always #2.5 clock = ~clock;
	bal_alu i_bal_alu (.clock(clock), .rst(rst), .op_valid(op_valid), .op_code(op_code),
		.src_operand(src_operand), .dst_operand(dst_operand), .load_aux(load_aux),
		.aux_load_value(aux_load_value), .flag_load(flag_load),
		.flag_load_value(flag_load_value), .op_ready(op_ready), .op_done(op_done),
		.work_reg(work_reg), .aux_reg(aux_reg), .carry_flag(carry_flag),
		.signed_wrap_flag(signed_wrap_flag), .nibble_carry_flag(nibble_carry_flag),
		.branch_taken(branch_taken));
	bal_seq_model i_bal_seq_model (.clock(clock), .op_ready(op_ready), .op_done(op_done),
		.branch_taken(branch_taken), .op_valid(op_valid), .op_code(op_code),
		.src_operand(src_operand), .dst_operand(dst_operand), .load_aux(load_aux),
		.aux_load_value(aux_load_value), .flag_load(flag_load),
		.flag_load_value(flag_load_value));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("compares %0d failures %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic set(input logic [7:0] w, input logic [7:0] a, input logic [2:0] f);
		i_bal_seq_model.issue(bal_pkg::BAL_OP_LOAD, w, 8'h00, 1'b1, a, 1'b1, f);
		if (i_bal_seq_model.lat >= 20)
			n_mismatch++;
	endtask
	task automatic run(input bal_pkg::bal_op_e op, input logic [7:0] s, input logic [7:0] d);
		i_bal_seq_model.issue(op, s, d, 1'b0, 8'h00, 1'b0, 3'b000);
		if (i_bal_seq_model.lat >= 20)
			n_mismatch++;
	endtask
	// Result byte, then carry, signed wrap and nibble carry.
	function automatic logic [10:0] arith_exp(input logic sub, input logic [7:0] a,
		input logic [7:0] b, input logic ci);
		logic [8:0] s;
		logic [7:0] m;
		logic [4:0] l;
		s = sub ? {1'b0, a} - {1'b0, b} - ci : {1'b0, a} + {1'b0, b} + ci;
		m = sub ? {1'b0, a[6:0]} - {1'b0, b[6:0]} - ci : {1'b0, a[6:0]} + {1'b0, b[6:0]} + ci;
		l = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - ci : {1'b0, a[3:0]} + {1'b0, b[3:0]} + ci;
		return {s[7:0], s[8], s[8] ^ m[7], l[4]};
	endfunction
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk({work_reg, aux_reg}, 16'h0000);
		chk({12'h000, op_ready, flg}, 16'h0008);
		$display("test reset done");
	endtask
	task automatic t_arith(input logic sub);
		logic [10:0] e;
		for (int k = 0; k < 2; k++)
			for (int i = 0; i < 6; i++)
				for (int c = 0; c < 2; c++)
				begin
					set(VA[i], 8'h5a, {c[0], ~c[0], ~c[0]});
					run(sub ? bal_pkg::BAL_OP_SUB : (k ? bal_pkg::BAL_OP_ADD_CARRY : bal_pkg::BAL_OP_ADD),
						VB[i], 8'h00);
					e = arith_exp(sub, VA[i], VB[i], (sub || k) && c);
					chk({work_reg, aux_reg}, {e[10:3], 8'h5a});
					chk({13'h0000, flg}, {13'h0000, e[2:0]});
				end
		$display("test arith done");
	endtask
	task automatic t_mul;
		logic [7:0]  ma [2] = '{8'hff, 8'h0f};
		logic [7:0]  mb [2] = '{8'hff, 8'h11};
		logic [2:0]  fp [2] = '{3'b101, 3'b110};
		logic [15:0] p;
		for (int i = 0; i < 2; i++)
		begin
			set(ma[i], mb[i], fp[i]);
			run(bal_pkg::BAL_OP_PROD, 8'h00, 8'h00);
			p = ma[i] * mb[i];
			chk({work_reg, aux_reg}, {p[7:0], p[15:8]});
			chk({13'h0000, flg}, {13'h0000, 1'b0, p > 16'h00ff, fp[i][0]});
		end
		$display("test mul done");
	endtask
	task automatic t_div;
		set(8'hfb, 8'h07, 3'b111);
		run(bal_pkg::BAL_OP_DIV, 8'h00, 8'h00);
		chk({work_reg, aux_reg}, {8'hfb / 8'h07, 8'hfb % 8'h07});
		chk({13'h0000, flg}, 16'h0001);
		chk(16'(i_bal_seq_model.lat), 16'h000a);
		set(8'h42, 8'h00, 3'b100);
		run(bal_pkg::BAL_OP_DIV, 8'h00, 8'h00);
		chk({13'h0000, flg}, 16'h0002);
		chk({work_reg, aux_reg}, 16'h4200);
		$display("test div done");
	endtask
	task automatic t_bcd;
		logic [7:0] bw [5] = '{8'h9a, 8'h15, 8'h45, 8'h23, 8'hfa};
		logic [2:0] bf [5] = '{3'b010, 3'b011, 3'b110, 3'b000, 3'b000};
		logic       lo;
		logic [9:0] sm;
		for (int i = 0; i < 5; i++)
		begin
			lo = bf[i][0] || bw[i][3:0] > 4'h9;
			sm = {2'b00, bw[i]} + (lo ? 10'h006 : 10'h000) + ((bf[i][2] || lo) ? 10'h060 : 10'h000);
			set(bw[i], 8'h3c, bf[i]);
			run(bal_pkg::BAL_OP_BCD, 8'h00, 8'h00);
			chk({work_reg, aux_reg}, {sm[7:0], 8'h3c});
			chk({13'h0000, flg}, {13'h0000, sm > 10'h099, bf[i][1:0]});
		end
		$display("test bcd done");
	endtask
	task automatic t_rot;
		logic [7:0] rw [3] = '{8'h81, 8'h81, 8'h7e};
		logic       rc [3] = '{1'b0, 1'b1, 1'b1};
		for (int k = 0; k < 2; k++)
			for (int i = 0; i < 3; i++)
			begin
				set(rw[i], 8'h00, {rc[i], ~rc[i], rc[i]});
				run(k ? bal_pkg::BAL_OP_ROL : bal_pkg::BAL_OP_ROR, 8'h00, 8'h00);
				chk({8'h00, work_reg}, {8'h00, k ? {rw[i][6:0], rc[i]} : {rc[i], rw[i][7:1]}});
				chk({13'h0000, flg}, {13'h0000, k ? rw[i][7] : rw[i][0], ~rc[i], rc[i]});
			end
		$display("test rot done");
	endtask
	task automatic t_cmp;
		logic [7:0] cs [4] = '{8'h05, 8'h06, 8'h04, 8'hff};
		logic [7:0] cd [4] = '{8'h05, 8'h05, 8'h05, 8'h00};
		for (int i = 0; i < 4; i++)
		begin
			set(8'h77, 8'h33, 3'b011);
			run(bal_pkg::BAL_OP_CMP, cs[i], cd[i]);
			chk({15'h0000, i_bal_seq_model.br}, {15'h0000, cs[i] != cd[i]});
			chk({13'h0000, flg}, {13'h0000, cs[i] > cd[i], 2'b11});
		end
		$display("test cmp done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		t_reset;
		t_arith(1'b0);
		t_arith(1'b1);
		t_mul;
		t_div;
		t_bcd;
		t_rot;
		t_cmp;
		complete_run;
	end
	initial
	begin
		#20000;
		n_mismatch++;
		complete_run;
	end
endmodule
`default_nettype wire
